// File: logic/bus_sizing_seq.sv
// Dynamic bus sizing sequencer: splits operands into sized bus cycles
//
// Summary of operation
// - Low two address outputs carry byte offset 0..3 from the long-word base.
// - First cycle of an aligned long write drives all four operand bytes.
// - Word-port ack after aligned long write gives second word cycle at offset two.
// - Word to byte port takes two cycles, size word then size byte.
// - Byte aligned anywhere; word misaligned if odd; long unless divisible by four.
// - Misaligned data is split at port boundaries into bus cycles, never a fault.
// - Instruction fetch from an odd address raises an address error.
// - Long at offset one to word port: three cycles, sizes long, three, byte.
// - Word at odd address to word port completes in exactly two cycles.
// - Long at offset three to 32-bit port: one byte, then three bytes.
// - Word cycle counts per offset and port follow the documented table.
// - Long cycle counts per offset and port follow the documented table.
// - Instruction prefetch always reads one long word at offset zero.
// - Odd-word instruction still fetches all 32 bits.
// - Fetched 32 bits are latched in a holding register for later use.
// - Size outputs give bytes still to move: byte, word, three, long.
`timescale 1ns/1ps
`include "bus_sizing_map.svh"
module bus_sizing_seq
    import bus_sizing_pkg::*;
#(
    // Data bus width in bits; the byte lane helpers serve 32 only
    parameter int DATA_W = 32
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request side
    input wire logic req_valid,
    input wire xfer_req_t req,
    output logic req_ready,
    output logic done,
    output logic addr_error,
    output logic [31:0] rdata,
    output logic [2:0] cycles_used,
    output logic misaligned,
    // Instruction holding register
    output logic [31:0] fetch_hold,
    output logic fetch_hold_valid,
    // Bus side
    output logic bus_active,
    output logic [31:0] bus_addr,
    output logic xfer_size_bit0,
    output logic xfer_size_bit1,
    output logic bus_write,
    output logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic port_ack_high,
    input wire logic port_ack_low
);
    // Registered state and its next value
    seq_state_vec_t s_r;
    seq_state_vec_t s_nxt;

    // Per-cycle helpers
    logic [1:0] port_width_acks;
    logic [2:0] moved;
    logic [2:0] req_count;
    logic req_misaligned;
    logic [31:0] placed;
    logic [31:0] merged;
    logic [31:0] next_addr;
    logic [2:0] next_left;

    // Byte lanes on the data bus
    localparam int LANES = DATA_W / `LANE_BITS;

    // Refuse a data bus the byte lane helpers cannot serve
    if (DATA_W != 32)
    begin : g_width_check
        $error("bus_sizing_seq serves a 32-bit data bus only");
    end

    assign port_width_acks = {port_ack_high, port_ack_low};

    // Bytes accepted by the slave in this cycle
    bus_chunk_calc chunk_calc (
        .offset(s_r.bus.addr[1:0]),
        .remaining(s_r.remaining),
        .ack_code(port_width_acks),
        .moved(moved)
    );

    // Size code to byte count and alignment check of a new request
    always_comb
    begin
        // Operand byte count
        case (req.size)
            OPER_BYTE: req_count = `COUNT_BYTE;
            OPER_WORD: req_count = `COUNT_WORD;
            default: req_count = `COUNT_LONG;
        endcase
        // Alignment by operand size
        case (req.size)
            OPER_BYTE: req_misaligned = 1'b0;
            OPER_WORD: req_misaligned = req.addr[0];
            default: req_misaligned = |req.addr[1:0];
        endcase
    end

    // Place the remaining operand bytes, high first, from the current lane
    function automatic logic [31:0] place_bytes(input logic [31:0] op,
                                                input logic [2:0] left,
                                                input logic [1:0] off);
        logic [31:0] bytes;
        logic [31:0] out;
        bytes = op << (`LANE_BITS * (3'h4 - left));
        out = 32'h0;
        for (int lane = 0; lane < LANES; lane++)
        begin
            // Lane holds the operand byte aimed at its byte address
            if (lane >= off)
                out[31 - lane*8 -: 8] = bytes[31 - (lane - off)*8 -: 8];
            // At offset two the upper half repeats the lower half for word ports
            else if (off == 2'h2)
                out[31 - lane*8 -: 8] = bytes[31 - lane*8 -: 8];
            // Elsewhere the first byte, where byte ports and odd word lanes look
            else
                out[31 - lane*8 -: 8] = bytes[31 -: 8];
        end
        return out;
    endfunction

    // Collect read bytes from the lanes the port width dictates
    function automatic logic [31:0] gather_bytes(input logic [31:0] acc,
                                                 input logic [31:0] d,
                                                 input logic [1:0] ack,
                                                 input logic [1:0] off,
                                                 input logic [2:0] n);
        logic [31:0] out;
        logic [1:0] lane;
        out = acc;
        for (int k = 0; k < LANES; k++)
        begin
            if (k < n)
            begin
                case (ack)
                    `ACK_PORT8: lane = 2'h0;
                    `ACK_PORT16: lane = {1'b0, off[0]} + k[1:0];
                    default: lane = off + k[1:0];
                endcase
                out = {out[23:0], d[31 - lane*8 -: 8]};
            end
        end
        return out;
    endfunction

    // Next address and remaining count after an acknowledge
    always_comb
    begin
        next_addr = s_r.bus.addr + {29'h0, moved};
        next_left = s_r.remaining - moved;
        placed = place_bytes(s_r.operand, next_left, next_addr[1:0]);
        merged = gather_bytes(s_r.rdata, bus_rdata, port_width_acks,
                              s_r.bus.addr[1:0], moved);
    end

    // Size code from bytes left
    function automatic logic [1:0] size_of(input logic [2:0] left);
        case (left)
            `COUNT_BYTE: return `SIZE_BYTE;
            `COUNT_WORD: return `SIZE_WORD;
            3'h3: return `SIZE_THREE;
            default: return `SIZE_LONG;
        endcase
    endfunction

    // Sequencer next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.state)
            ST_IDLE:
            begin
                if (req_valid && s_r.ready)
                begin
                    // Fresh operation: clear the error and the read collector
                    s_nxt.addr_error = 1'b0;
                    s_nxt.rdata = 32'h0;
                    s_nxt.cycles = 3'h0;
                    // Misaligned data is flagged but still runs
                    s_nxt.misaligned = req_misaligned && !req.fetch;
                    // Fetches and aligned long reads refill the holding register
                    s_nxt.hold_load = req.fetch
                        || (!req.write && req.size == OPER_LONG && req.addr[1:0] == 2'h0);
                    if (req.fetch && req.addr[0])
                    begin
                        s_nxt.addr_error = 1'b1;
                        s_nxt.done = 1'b1;
                    end
                    else
                    begin
                        // Misaligned data proceeds with no fault
                        s_nxt.state = ST_CYCLE;
                        s_nxt.bus_active = 1'b1;
                        s_nxt.bus.write = req.write && !req.fetch;
                        s_nxt.operand = req.data;
                        if (req.fetch)
                        begin
                            // Whole long word from its base
                            s_nxt.bus.addr = {req.addr[31:2], 2'h0};
                            s_nxt.remaining = `COUNT_LONG;
                            s_nxt.bus.size_code = `SIZE_LONG;
                            s_nxt.fetch_hold_valid = 1'b0;
                        end
                        else
                        begin
                            s_nxt.bus.addr = req.addr;
                            s_nxt.remaining = req_count;
                            s_nxt.bus.size_code = size_of(req_count);
                        end
                        // Operand bytes up to the end of the long word driven from the first cycle
                        s_nxt.bus.wdata = place_bytes(req.data,
                            req.fetch ? `COUNT_LONG : req_count, req.addr[1:0]);
                    end
                end
            end
            ST_CYCLE:
            begin
                // Outputs held while the slave inserts wait states
                if (port_width_acks != `ACK_WAIT)
                begin
                    // Count the cycle and keep the bytes it brought
                    s_nxt.cycles = s_r.cycles + 3'h1;
                    s_nxt.rdata = merged;
                    if (next_left == `COUNT_ZERO)
                    begin
                        // Last bytes moved: close the operation
                        s_nxt.state = ST_DONE;
                        s_nxt.bus_active = 1'b0;
                        s_nxt.done = 1'b1;
                        if (s_r.hold_load)
                        begin
                            s_nxt.fetch_hold = merged;
                            s_nxt.fetch_hold_valid = 1'b1;
                        end
                    end
                    else
                    begin
                        // Follow-on cycle for the leftover bytes
                        s_nxt.bus.addr = next_addr;
                        s_nxt.remaining = next_left;
                        s_nxt.bus.size_code = size_of(next_left);
                        s_nxt.bus.wdata = placed;
                    end
                end
            end
            ST_DONE:
            begin
                // One recovery cycle before the next request
                s_nxt.state = ST_IDLE;
            end
            default:
            begin
                // Unused code falls back to idle
                s_nxt.state = ST_IDLE;
            end
        endcase

        // Ready is registered so that every output leaves a flip-flop
        s_nxt.ready = (s_nxt.state == ST_IDLE);
    end

    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Request side results come straight from the state register
    assign req_ready = s_r.ready;
    assign done = s_r.done;
    assign addr_error = s_r.addr_error;
    assign rdata = s_r.rdata;
    assign cycles_used = s_r.cycles;
    assign misaligned = s_r.misaligned;

    // Instruction holding register
    assign fetch_hold = s_r.fetch_hold;
    assign fetch_hold_valid = s_r.fetch_hold_valid;

    // Bus cycle outputs
    assign bus_active = s_r.bus_active;
    assign bus_addr = s_r.bus.addr;
    assign xfer_size_bit0 = s_r.bus.size_code[0];
    assign xfer_size_bit1 = s_r.bus.size_code[1];
    assign bus_write = s_r.bus.write;
    assign bus_wdata = s_r.bus.wdata;
endmodule // bus_sizing_seq

// File: logic/bus_sizing_map.svh
// Encodings and widths used by the dynamic bus sizing sequencer
`ifndef BUS_SIZING_MAP_SVH
`define BUS_SIZING_MAP_SVH

// Size output codes: bytes left to move in the current cycle
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_THREE 2'h3

// Acknowledge codes {port_ack_high, port_ack_low}, active high inside the block
`define ACK_WAIT 2'h0
`define ACK_PORT8 2'h1
`define ACK_PORT16 2'h2
`define ACK_PORT32 2'h3

// Operand byte counts
`define COUNT_BYTE 3'h1
`define COUNT_WORD 3'h2
`define COUNT_LONG 3'h4
`define COUNT_ZERO 3'h0

// Byte lane positions on the 32-bit data bus, lane 0 is bits 31:24
`define LANE_BITS 8
`define LOW_OFFSET_MASK 2'h3

`endif

// File: logic/bus_sizing_pkg.sv
// Types shared by the bus sizing sequencer and its chunk calculator
package bus_sizing_pkg;

    typedef enum logic [1:0] {
        OPER_BYTE = 2'b01,
        OPER_WORD = 2'b10,
        OPER_LONG = 2'b00
    } oper_size_t;

    // One request from the execution side
    typedef struct packed {
        logic [31:0] addr;
        oper_size_t size;
        logic write;
        logic fetch;
        logic [31:0] data;
    } xfer_req_t;

    // Bus cycle outputs that stay steady for a whole cycle
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] size_code;
        logic write;
        logic [31:0] wdata;
    } bus_cycle_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CYCLE = 2'b01,
        ST_DONE = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        bus_cycle_t bus;
        logic bus_active;
        logic [2:0] remaining;
        logic [31:0] operand;
        logic [31:0] rdata;
        logic [2:0] cycles;
        logic done;
        logic addr_error;
        logic [31:0] fetch_hold;
        logic fetch_hold_valid;
        logic ready;
        logic misaligned;
        logic hold_load;
    } seq_state_vec_t;

endpackage

// File: logic/bus_chunk_calc.sv
// Bytes a slave can take this cycle from port width, offset and remaining count
`timescale 1ns/1ps
`include "bus_sizing_map.svh"
module bus_chunk_calc
    import bus_sizing_pkg::*;
(
    // Cycle context
    input wire logic [1:0] offset,
    input wire logic [2:0] remaining,
    input wire logic [1:0] ack_code,
    // Result
    output logic [2:0] moved
);
    logic [2:0] room;

    // Port room from the offset to the end of the port
    always_comb
    begin
        case (ack_code)
            `ACK_PORT8: room = `COUNT_BYTE;
            `ACK_PORT16: room = `COUNT_WORD - {2'h0, offset[0]};
            `ACK_PORT32: room = `COUNT_LONG - {1'b0, offset};
            default: room = `COUNT_ZERO;
        endcase
        moved = (remaining < room) ? remaining : room;
    end
endmodule // bus_chunk_calc

// File: verification/seq_checker_properties.sv
// Port-level checks for the bus sizing sequencer
`timescale 1ns/1ps
module seq_checker
    import bus_sizing_pkg::*;
(
    // Clock, reset and request side
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire xfer_req_t req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic addr_error,
    // Bus side
    input wire logic bus_active,
    input wire logic [31:0] bus_addr,
    input wire logic xfer_size_bit0,
    input wire logic xfer_size_bit1,
    input wire logic bus_write,
    input wire logic [31:0] bus_wdata,
    input wire logic port_ack_high,
    input wire logic port_ack_low
);
    // Grouped codes and events
    wire logic [1:0] sz = {xfer_size_bit1, xfer_size_bit0};
    wire logic [1:0] ak = {port_ack_high, port_ack_low};
    wire logic take = req_valid && req_ready;
    wire logic acked = bus_active && ak != 2'h0;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    hold_on_wait_a: assert property (bus_active && ak == 2'h0 |=> bus_active && $stable(bus_addr)
        && $stable(sz) && $stable(bus_wdata)) else $error("cycle moved in wait");
    first_long_a: assert property (take && req.write && !req.fetch && req.size == OPER_LONG
        && req.addr[1:0] == 2'h0 |=> sz == 2'h0 && bus_wdata == $past(req.data))
        else $error("first long write");
    word_port_a: assert property (acked && ak == 2'h2 && bus_write && sz == 2'h0
        && bus_addr[1:0] == 2'h0 |=> sz == 2'h2 && bus_addr == $past(bus_addr) + 32'h2
        && bus_wdata[31:16] == $past(bus_wdata[15:0])) else $error("word port tail");
    byte_step_a: assert property (acked && ak == 2'h1 && sz != 2'h1 |=> bus_active
        && sz == $past(sz) - 2'h1 && bus_addr == $past(bus_addr) + 32'h1)
        else $error("byte port step");
    odd_long_a: assert property (acked && ak == 2'h2 && sz == 2'h0 && bus_addr[1:0] == 2'h1
        |=> sz == 2'h3 && bus_addr == $past(bus_addr) + 32'h1) else $error("odd long");
    long_tail_a: assert property (acked && ak == 2'h3 && sz == 2'h0 && bus_addr[1:0] == 2'h3
        |=> sz == 2'h3 && bus_addr == $past(bus_addr) + 32'h1)
        else $error("long at three");
    tail_end_a: assert property (acked && ak == 2'h3 && sz == 2'h3 && bus_addr[1:0] == 2'h0
        |=> done && !bus_active) else $error("cycles after tail");
    odd_fetch_a: assert property (take && req.fetch && req.addr[0] |=> done && addr_error
        && !bus_active) else $error("odd fetch");
    fetch_base_a: assert property (take && req.fetch && !req.addr[0] |=> bus_active
        && sz == 2'h0 && bus_addr[1:0] == 2'h0) else $error("fetch base");
    // Main scenarios reached
    cover property (acked && ak == 2'h1);
    cover property (acked && ak == 2'h2 && sz == 2'h3);
    cover property (take && req.fetch && req.addr[0]);
endmodule // seq_checker

bind bus_sizing_seq seq_checker u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .addr_error(addr_error),
    .bus_active(bus_active), .bus_addr(bus_addr), .xfer_size_bit0(xfer_size_bit0),
    .xfer_size_bit1(xfer_size_bit1), .bus_write(bus_write), .bus_wdata(bus_wdata),
    .port_ack_high(port_ack_high), .port_ack_low(port_ack_low));

// File: verification/slave_port_model.sv
// Far-side slave port with bench-selected width and wait states
`timescale 1ns/1ps
module slave_port_model (
    // Clock, reset and bus cycle
    input wire logic clock,
    input wire logic rst,
    input wire logic bus_active,
    input wire logic [31:0] bus_addr,
    // Behaviour and answer
    input wire logic [1:0] port_code,
    input wire logic [1:0] wait_n,
    output logic ack_high,
    output logic ack_low,
    output logic [31:0] rdata
);
    logic [1:0] cnt_r;
    logic [31:0] base;
    logic [31:0] junk;
    // Port-aligned address; lanes the port does not own carry garbage
    assign base = bus_addr & ~((32'h1 << (port_code - 2'h1)) - 32'h1);
    assign junk = port_code == 2'h3 ? 32'h0 : (port_code == 2'h2 ? 32'hffff : 32'hffffff);
    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    // Waits, then acknowledges with the port width for one cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            {ack_high, ack_low} <= 2'h0;
            cnt_r <= 2'h0;
            rdata <= 32'h0;
        end
        else if (bus_active && {ack_high, ack_low} == 2'h0 && cnt_r == wait_n)
        begin
            {ack_high, ack_low} <= port_code;
            cnt_r <= 2'h0;
            rdata <= {mem_byte(base), mem_byte(base + 1), mem_byte(base + 2),
                mem_byte(base + 3)} ^ junk;
        end
        else
        begin
            {ack_high, ack_low} <= 2'h0;
            cnt_r <= (bus_active && {ack_high, ack_low} == 2'h0) ? cnt_r + 2'h1 : 2'h0;
            rdata <= ~rdata;
        end
    end
endmodule // slave_port_model

// File: verification/bus_sizing_seq_tb.sv
// Self-checking bench for the bus sizing sequencer
`timescale 1ns/1ps
module bus_sizing_seq_tb
    import bus_sizing_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    xfer_req_t req = '0;
    logic [1:0] port_code = 2'h3;
    logic [1:0] wait_n = 2'h0;
    logic req_ready, done, addr_error, fetch_hold_valid, bus_active, bus_write, misaligned;
    logic ack_high, ack_low, size_b0, size_b1;
    logic [31:0] rdata, fetch_hold, bus_addr, bus_wdata, bus_rdata;
    logic [2:0] cycles_used;
    int mismatches = 0;
    int check_count = 0;
    // Bus cycles per operand size, offset and port width 32:16:8
    int tbl [3][4][3] = '{'{'{1, 1, 1}, '{1, 1, 1}, '{1, 1, 1}, '{1, 1, 1}},
        '{'{1, 1, 2}, '{1, 2, 2}, '{1, 1, 2}, '{2, 2, 2}},
        '{'{1, 2, 4}, '{2, 3, 4}, '{2, 2, 4}, '{2, 3, 4}}};
    oper_size_t sizes [3] = '{OPER_BYTE, OPER_WORD, OPER_LONG};
    initial forever #25 clock = ~clock;
    bus_sizing_seq uut (.clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .addr_error(addr_error), .rdata(rdata),
        .cycles_used(cycles_used), .misaligned(misaligned), .fetch_hold(fetch_hold),
        .fetch_hold_valid(fetch_hold_valid), .bus_active(bus_active), .bus_addr(bus_addr),
        .xfer_size_bit0(size_b0), .xfer_size_bit1(size_b1), .bus_write(bus_write),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .port_ack_high(ack_high),
        .port_ack_low(ack_low));
    slave_port_model slave (.clock(clock), .rst(rst), .bus_active(bus_active),
        .bus_addr(bus_addr), .port_code(port_code), .wait_n(wait_n), .ack_high(ack_high),
        .ack_low(ack_low), .rdata(bus_rdata));
    // Operand bytes starting at an address, right-justified
    function automatic logic [31:0] exp_read(input logic [31:0] a, input int nb);
        logic [31:0] v = 32'h0;
        for (int i = 0; i < nb; i++)
            v = {v[23:0], 8'(a[7:0] + 8'(i)) ^ 8'h5a};
        return v;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One request, then a bounded wait for its completion pulse
    task automatic run_op(input logic [31:0] a, input oper_size_t s, input logic w,
        input logic f);
        int n = 0;
        // Let at least one edge pass so the strobe is never set twice at once
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (req_ready !== 1'b1 && n < 20);
        if (req_ready !== 1'b1)
        begin
            mismatches++;
            tally_and_finish();
        end
        req = '{addr: a, size: s, write: w, fetch: f, data: 32'h8c4d2e17 ^ a};
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (done !== 1'b1)
        begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    // Every size, offset and port width with varied waits, reads and writes
    task automatic count_table();
        logic [31:0] a;
        logic mis_exp;
        for (int si = 0; si < 3; si++)
            for (int o = 0; o < 4; o++)
                for (int p = 0; p < 3; p++)
                begin
                    a = 32'h140 + 32'(o);
                    port_code = 2'(3 - p);
                    wait_n = 2'(p);
                    run_op(a, sizes[si], 1'(o + p), 1'b0);
                    check("cycles", 32'(cycles_used), 32'(tbl[si][o][p]));
                    mis_exp = (si == 1 && o[0]) || (si == 2 && o != 0);
                    check("misaligned", 32'(misaligned), 32'(mis_exp));
                    if (!req.write)
                        check("rdata", rdata & ~(32'hffffffff << (8 << si)),
                            exp_read(a, 1 << si));
                end
    endtask
    // Prefetches from even and odd addresses on each port width
    task automatic fetch_checks();
        for (int p = 0; p < 3; p++)
        begin
            port_code = 2'(3 - p);
            run_op(32'h2a6, OPER_LONG, 1'b0, 1'b1);
            check("fetch cycles", 32'(cycles_used), 32'(tbl[2][0][p]));
            check("hold", fetch_hold, exp_read(32'h2a4, 4));
            check("hold valid", 32'(fetch_hold_valid), 32'h1);
            run_op(32'h2a7, OPER_LONG, 1'b0, 1'b1);
            check("odd fetch", 32'(addr_error), 32'h1);
        end
        run_op(32'h2a8, OPER_BYTE, 1'b1, 1'b0);
        check("error clear", 32'(addr_error), 32'h0);
    endtask
    // Reset, scenarios, verdict
    initial
    begin
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        count_table();
        fetch_checks();
        tally_and_finish();
    end
endmodule // bus_sizing_seq_tb
